// ===== hdl/asrc_ctrl.sv
`timescale 1ns/1ps
`include "asrc_regs.svh"

module asrc_ctrl #(
    parameter int POWERUP_CYC = `ASRC_POWERUP_CYC
) (
    input  wire logic                clock,
    input  wire logic                arst_n,
    input  wire logic                req,
    input  wire logic                req_write,
    input  wire asrc_pkg::asrc_addr_t req_addr,
    input  wire asrc_pkg::asrc_data_t req_wdata,
    output logic                     busy,
    output asrc_pkg::asrc_data_t     rd_data,
    output logic                     rd_valid,
    output logic                     sram_ce_n,
    output logic                     sram_oe_n,
    output logic                     sram_we_n,
    output asrc_pkg::asrc_addr_t     location_lines,
    output asrc_pkg::asrc_data_t     shared_data_lines_o,
    output logic                     shared_data_lines_oe,
    input  wire asrc_pkg::asrc_data_t shared_data_lines_i
);
    import asrc_pkg::*;

    localparam int        WPULSE_CYC = `ASRC_WPULSE_CYC;
    localparam int        READ_CYC   = `ASRC_READ_CYC;
    localparam int        TURN_CYC   = `ASRC_TURN_CYC;
    localparam asrc_cnt_t PU_LAST    = asrc_cnt_t'(POWERUP_CYC - 1);
    localparam asrc_cnt_t WP_LAST    = asrc_cnt_t'(WPULSE_CYC - 1);
    localparam asrc_cnt_t RD_LAST    = asrc_cnt_t'(READ_CYC - 1);
    localparam asrc_cnt_t TN_LAST    = asrc_cnt_t'(TURN_CYC - 1);

    logic        rst_n;
    asrc_state_t state_q;
    asrc_state_t state_d;
    asrc_cnt_t   cnt_q;
    asrc_cnt_t   cnt_d;
    asrc_data_t  din_s;
    logic        take;

    // ------------------------------------------------------------------
    // reset release and data input synchronisers
    // ------------------------------------------------------------------
    asrc_sync #(.WIDTH(1)) u_rst_sync (
        .clock (clock),
        .rst_n (arst_n),
        .din   (1'B1),
        .dout  (rst_n)
    );

    asrc_sync #(.WIDTH(`ASRC_DATA_W)) u_din_sync (
        .clock (clock),
        .rst_n (rst_n),
        .din   (shared_data_lines_i),
        .dout  (din_s)
    );

    // ------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------
    assign take = (state_q == ASRC_ST_IDLE) && req;

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q + asrc_cnt_t'(1);
        unique case (state_q)
            ASRC_ST_POWERUP: begin
                if (cnt_q == PU_LAST) begin
                    state_d = ASRC_ST_IDLE;
                    cnt_d   = '0;
                end
            end
            ASRC_ST_IDLE: begin
                cnt_d = '0;
                if (req) begin
                    state_d = req_write ? ASRC_ST_WSETUP : ASRC_ST_READ;
                end
            end
            ASRC_ST_WSETUP: begin
                state_d = ASRC_ST_WPULSE;
                cnt_d   = '0;
            end
            ASRC_ST_WPULSE: begin
                if (cnt_q == WP_LAST) begin
                    state_d = ASRC_ST_WEND;
                    cnt_d   = '0;
                end
            end
            ASRC_ST_WEND: begin
                state_d = ASRC_ST_IDLE;
                cnt_d   = '0;
            end
            ASRC_ST_READ: begin
                if (cnt_q == RD_LAST) begin
                    state_d = ASRC_ST_TURN;
                    cnt_d   = '0;
                end
            end
            ASRC_ST_TURN: begin
                if (cnt_q == TN_LAST) begin
                    state_d = ASRC_ST_IDLE;
                    cnt_d   = '0;
                end
            end
            default: begin
                state_d = ASRC_ST_IDLE;
                cnt_d   = '0;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ASRC_ST_POWERUP;
            cnt_q   <= '0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    // ------------------------------------------------------------------
    // memory pins
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sram_ce_n <= `ASRC_PIN_IDLE;
            sram_oe_n <= `ASRC_PIN_IDLE;
            sram_we_n <= `ASRC_PIN_IDLE;
        end else begin
            sram_ce_n <= !(state_d inside {ASRC_ST_WSETUP, ASRC_ST_WPULSE, ASRC_ST_WEND, ASRC_ST_READ});
            sram_we_n <= (state_d != ASRC_ST_WPULSE);
            sram_oe_n <= (state_d != ASRC_ST_READ);
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            location_lines       <= '0;
            shared_data_lines_o  <= '0;
            shared_data_lines_oe <= 1'B0;
        end else begin
            if (take) begin
                location_lines      <= req_addr;
                shared_data_lines_o <= req_wdata;
            end
            // data stays driven one cycle past the strobe rising edge
            shared_data_lines_oe <= state_d inside {ASRC_ST_WSETUP, ASRC_ST_WPULSE, ASRC_ST_WEND};
        end
    end

    // ------------------------------------------------------------------
    // user side
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            busy     <= 1'B1;
            rd_valid <= 1'B0;
            rd_data  <= '0;
        end else begin
            busy     <= (state_d != ASRC_ST_IDLE);
            rd_valid <= (state_q == ASRC_ST_READ) && (cnt_q == RD_LAST);
            if ((state_q == ASRC_ST_READ) && (cnt_q == RD_LAST)) begin
                rd_data <= din_s;
            end
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    asrc_cnt_t up_cnt_q;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            up_cnt_q <= '0;
        end else if (up_cnt_q != '1) begin
            up_cnt_q <= up_cnt_q + asrc_cnt_t'(1);
        end
    end

    strobe_needs_ce_a: assert property (@(posedge clock) disable iff (!rst_n)
        !sram_we_n |-> !sram_ce_n)
        else $error("write strobe low without chip select");

    data_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(sram_we_n) |-> shared_data_lines_oe && !sram_ce_n)
        else $error("write data released before write end");

    write_length_a: assert property (@(posedge clock) disable iff (!rst_n)
        $fell(sram_we_n) |-> !sram_we_n [*2] ##1 sram_we_n)
        else $error("write strobe pulse length wrong");

    no_contention_a: assert property (@(posedge clock) disable iff (!rst_n)
        shared_data_lines_oe |-> sram_oe_n && $past(sram_oe_n))
        else $error("data driven while memory may drive");

    powerup_wait_a: assert property (@(posedge clock) disable iff (!rst_n)
        !sram_ce_n |-> up_cnt_q >= asrc_cnt_t'(POWERUP_CYC))
        else $error("access before power-up wait");

    read_done_a: assert property (@(posedge clock) disable iff (!rst_n)
        $fell(sram_oe_n) |-> !sram_oe_n [*4] ##1 (sram_oe_n && rd_valid) ##1 !shared_data_lines_oe)
        else $error("read sequence timing wrong");

    addr_stable_a: assert property (@(posedge clock) disable iff (!rst_n)
        !sram_ce_n && !$past(sram_ce_n) |-> $stable(location_lines))
        else $error("address changed during access");

    write_data_stable_a: assert property (@(posedge clock) disable iff (!rst_n)
        !sram_we_n |-> $stable(shared_data_lines_o))
        else $error("write data changed under strobe");

    write_oe_high_a: assert property (@(posedge clock) disable iff (!rst_n)
        !sram_we_n |-> sram_oe_n && shared_data_lines_oe)
        else $error("output enable low during write");

    read_turnaround_a: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(sram_oe_n) |-> !shared_data_lines_oe ##1 !shared_data_lines_oe)
        else $error("data driven inside read turnaround");

    powerup_busy_a: assert property (@(posedge clock) disable iff (!rst_n)
        up_cnt_q < asrc_cnt_t'(POWERUP_CYC) |-> busy)
        else $error("idle before power-up wait ends");

endmodule : asrc_ctrl

// ===== hdl/asrc_pkg.sv
`include "asrc_regs.svh"

package asrc_pkg;

    typedef logic [`ASRC_ADDR_W-1:0] asrc_addr_t;
    typedef logic [`ASRC_DATA_W-1:0] asrc_data_t;
    typedef logic [`ASRC_CNT_W-1:0]  asrc_cnt_t;

    typedef enum logic [7:0] {
        ASRC_ST_POWERUP = 8'H01,
        ASRC_ST_IDLE    = 8'H02,
        ASRC_ST_WSETUP  = 8'H04,
        ASRC_ST_WPULSE  = 8'H08,
        ASRC_ST_WEND    = 8'H10,
        ASRC_ST_READ    = 8'H20,
        ASRC_ST_TURN    = 8'H40,
        ASRC_ST_SPARE   = 8'H80
    } asrc_state_t;

endpackage : asrc_pkg

// ===== hdl/asrc_regs.svh
`ifndef ASRC_REGS_SVH
`define ASRC_REGS_SVH

// ----------------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------------
`define ASRC_CLK_MHZ                    100
`define ASRC_POWERUP_WAIT_TIME_US       100
`define ASRC_WRITE_PULSE_NS             7
`define ASRC_WRITE_DATA_SETUP_TIME_NS   6
`define ASRC_WRITE_STROBE_FLOAT_DELAY_NS 5
`define ASRC_ADDR_TO_DATA_NS            10
`define ASRC_OE_FLOAT_NS                5
`define ASRC_SYNC_STAGES                2

// least time in ns to whole cycles, rounded up, at least one
`define ASRC_CYC_UP(ns) ((((ns) * `ASRC_CLK_MHZ + 999) / 1000) < 1 ? 1 : (((ns) * `ASRC_CLK_MHZ + 999) / 1000))

`define ASRC_POWERUP_CYC  (`ASRC_POWERUP_WAIT_TIME_US * `ASRC_CLK_MHZ)
`define ASRC_WPULSE_NS    ((`ASRC_WRITE_STROBE_FLOAT_DELAY_NS + `ASRC_WRITE_DATA_SETUP_TIME_NS) > \
                           `ASRC_WRITE_PULSE_NS ? (`ASRC_WRITE_STROBE_FLOAT_DELAY_NS + \
                           `ASRC_WRITE_DATA_SETUP_TIME_NS) : `ASRC_WRITE_PULSE_NS)
`define ASRC_WPULSE_CYC   `ASRC_CYC_UP(`ASRC_WPULSE_NS)
`define ASRC_READ_CYC     (`ASRC_CYC_UP(`ASRC_ADDR_TO_DATA_NS) + `ASRC_SYNC_STAGES + 1)
`define ASRC_TURN_CYC     `ASRC_CYC_UP(`ASRC_OE_FLOAT_NS)

// ----------------------------------------------------------------------
// widths and reset values
// ----------------------------------------------------------------------
`define ASRC_ADDR_W       17
`define ASRC_DATA_W       8
`define ASRC_CNT_W        14
`define ASRC_PIN_IDLE     1'B1

`endif

// ===== hdl/asrc_sync.sv
`timescale 1ns/1ps

module asrc_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta_q;

    // ------------------------------------------------------------------
    // two flip-flops per bit
    // ------------------------------------------------------------------
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
                meta_q[i] <= 1'B0;
                dout[i]   <= 1'B0;
            end else begin
                meta_q[i] <= din[i];
                dout[i]   <= meta_q[i];
            end
        end
    end

endmodule : asrc_sync

// ===== verif/asrc_mem_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// behavioural byte memory on the far side of the controller
// ----------------------------------------------------------------------
module asrc_mem_model #(
    parameter int POWERUP_NS = 200
) (
    input  wire logic                 ce_n,
    input  wire logic                 oe_n,
    input  wire logic                 we_n,
    input  wire asrc_pkg::asrc_addr_t addr,
    input  wire asrc_pkg::asrc_data_t dq_in,
    input  wire logic                 host_oe,
    output asrc_pkg::asrc_data_t      dq_out,
    output logic                      clash,
    output logic                      early
);
    import asrc_pkg::*;
    asrc_data_t mem [asrc_addr_t];
    asrc_data_t last_q;
    logic       wr_act;
    logic       drive;
    logic       wr_open;

    initial begin
        wr_open = 1'b0;
        last_q = 8'H5A;
        clash  = 1'b0;
        early  = 1'b0;
    end

    assign wr_act = !ce_n && !we_n;
    assign drive  = !ce_n && !oe_n && we_n;

    // store on the first rising of select or strobe
    // only a real write opening arms the store, not the unknown-to-low step at reset
    always @(posedge wr_act) wr_open = 1'b1;

    always @(negedge wr_act) begin
        if (wr_open && ^addr !== 1'bx) mem[addr] = dq_in;
        wr_open = 1'b0;
    end

    // float faster than drive; floating lines show the inverse of the last value
    always @(drive, addr, last_q) begin
        if (drive) dq_out <= #2 (mem.exists(addr) ? mem[addr] : 8'H00);
        else dq_out <= #1 ~last_q;
    end

    always @(negedge drive) last_q = dq_out;

    always @(drive, host_oe) begin
        if (drive && host_oe) clash = 1'b1;
    end

    always @(negedge ce_n) begin
        if ($realtime < POWERUP_NS) early = 1'b1;
    end
endmodule : asrc_mem_model

// ===== verif/test_asrc_ctrl.sv
`timescale 1ns/1ps

module test_asrc_ctrl;
    import asrc_pkg::*;
    localparam int PWR = 20;
    logic       clock, arst_n, req, req_write, busy, rd_valid;
    logic       sram_ce_n, sram_oe_n, sram_we_n, dq_oe, clash, early;
    asrc_addr_t req_addr, location_lines, a_list[$];
    asrc_data_t req_wdata, rd_data, dq_o, dq_i, mem_dq;
    asrc_data_t exp_q[$];
    asrc_data_t shadow [asrc_addr_t];
    int         mismatches = 0;
    int         n_checks = 0;

    assign dq_i = dq_oe ? dq_o : mem_dq;

    asrc_ctrl #(.POWERUP_CYC(PWR)) i_asrc_ctrl (.clock(clock), .arst_n(arst_n), .req(req),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .busy(busy),
        .rd_data(rd_data), .rd_valid(rd_valid), .sram_ce_n(sram_ce_n), .sram_oe_n(sram_oe_n),
        .sram_we_n(sram_we_n), .location_lines(location_lines), .shared_data_lines_o(dq_o),
        .shared_data_lines_oe(dq_oe), .shared_data_lines_i(dq_i));

    asrc_mem_model #(.POWERUP_NS(PWR * 10)) i_asrc_mem_model (.ce_n(sram_ce_n), .oe_n(sram_oe_n),
        .we_n(sram_we_n), .addr(location_lines), .dq_in(dq_i), .host_oe(dq_oe), .dq_out(mem_dq),
        .clash(clash), .early(early));

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : close_out

    task automatic fail(input string msg);
        mismatches++;
        $display("BAD %0t %s", $time, msg);
    endtask : fail

    task automatic chk_rd(input asrc_data_t exp);
        n_checks++;
        if (rd_data !== exp) fail($sformatf("read %h want %h", rd_data, exp));
    endtask : chk_rd

    task automatic chk_flag(input logic got, input logic exp, input string what);
        n_checks++;
        if (got !== exp) fail(what);
    endtask : chk_flag

    task automatic wait_idle;
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 200) begin
            @(posedge clock);
            #1;
            n++;
        end
        if (busy !== 1'b0) begin
            fail("busy stuck");
            close_out();
        end
    endtask : wait_idle

    task automatic access(input logic w, input asrc_addr_t a, input asrc_data_t d);
        wait_idle();
        req       = 1'b1;
        req_write = w;
        req_addr  = a;
        req_wdata = d;
        if (w) shadow[a] = d;
        else exp_q.push_back(shadow.exists(a) ? shadow[a] : 8'H00);
        @(posedge clock);
        #1;
        req = 1'b0;
    endtask : access

    // ------------------------------------------------------------------
    // result watcher
    // ------------------------------------------------------------------
    always @(posedge clock) begin
        if (rd_valid === 1'b1) begin
            if (exp_q.size() == 0) fail("read with nothing expected");
            else chk_rd(exp_q.pop_front());
        end
    end

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        arst_n = 1'b0;
        req = 1'b0;
        req_write = 1'b0;
        req_addr = '0;
        req_wdata = '0;
        void'($urandom(32'h9163));
        repeat (4) @(posedge clock);
        #1;
        arst_n = 1'b1;
        access(1'b1, 17'h00000, 8'hA5);
        access(1'b1, 17'h1FFFF, 8'h3C);
        access(1'b0, 17'h00000, 8'h00);
        access(1'b0, 17'h1FFFF, 8'h00);
        $display("test boundary done");
        for (int i = 0; i < 16; i++) begin
            a_list.push_back(asrc_addr_t'($urandom()));
            access(1'b1, a_list[i], asrc_data_t'($urandom()));
            access(1'b0, a_list[i], 8'h00);
        end
        foreach (a_list[i]) access(1'b0, a_list[i], 8'h00);
        $display("test random done");
        access(1'b1, 17'h00123, 8'h11);
        access(1'b1, 17'h00456, 8'h55);
        @(posedge clock);
        #1;
        req = 1'b1;
        req_write = 1'b1;
        req_addr = 17'h00123;
        req_wdata = 8'hEE;
        repeat (2) @(posedge clock);
        #1;
        req = 1'b0;
        access(1'b0, 17'h00123, 8'h00);
        access(1'b0, 17'h00456, 8'h00);
        $display("test refused done");
        wait_idle();
        repeat (8) @(posedge clock);
        chk_flag(exp_q.size() == 0, 1'b1, "reads missing");
        chk_flag(clash, 1'b0, "bus contention");
        chk_flag(early, 1'b0, "access before power-up wait");
        $display("test flags done");
        close_out();
    end
endmodule : test_asrc_ctrl
